// ==== bench/fcd_checker.sv ====
// Port checker of the floppy configuration register bank.
`timescale 1ns/1ns
module fcd_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic writeProtectIn_n,
  input wire logic writeReq,
  input wire logic deviceActive,
  input wire logic [1:0] ctrlLow,
  input wire logic writeProtected,
  input wire logic writeGate,
  input wire logic [7:0] ctrlReadOut,
  input wire logic [7:0] pinOutEn_n
);
  // --------
  // Properties.
  // --------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_wp; nrst && !writeProtectIn_n |=> writeProtected; endproperty
  a_wp: assert property (p_wp) else $error("wp lost");
  property p_block; writeProtected |-> !writeGate; endproperty
  a_block: assert property (p_block) else $error("gate open");
  property p_idle; nrst && !writeReq |=> !writeGate; endproperty
  a_idle: assert property (p_idle) else $error("gate idle");
  property p_gsrc; writeGate |-> $past(writeReq) && $past(writeProtectIn_n); endproperty
  a_gsrc: assert property (p_gsrc) else $error("gate src");
  property p_fix; ctrlReadOut[7:6] == 2'h3 && ctrlReadOut[3:2] == 2'h3; endproperty
  a_fix: assert property (p_fix) else $error("ctrl ones");
  property p_low; $past(nrst) |-> ctrlReadOut[1:0] == $past(ctrlLow); endproperty
  a_low: assert property (p_low) else $error("ctrl low");
  property p_whole; pinOutEn_n == 8'h00 || pinOutEn_n == 8'hff; endproperty
  a_whole: assert property (p_whole) else $error("en split");
  property p_act; nrst && deviceActive |=> pinOutEn_n == 8'h00; endproperty
  a_act: assert property (p_act) else $error("en active");
  c_float: cover property (pinOutEn_n == 8'hff);
  c_block: cover property (writeProtected && writeReq);
  c_gate: cover property (writeGate);
endmodule : fcd_checker
bind floppy_config_drive_identifier_regs fcd_checker u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .writeProtectIn_n(writeProtectIn_n), .writeReq(writeReq), .deviceActive(deviceActive), .ctrlLow(ctrlLow),
  .writeProtected(writeProtected), .writeGate(writeGate), .ctrlReadOut(ctrlReadOut), .pinOutEn_n(pinOutEn_n));

// ==== bench/testbench.sv ====
// Testbench of the floppy configuration register bank.
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic [7:0] cfg; logic [6:0] ins; logic [7:0] ctl; logic [4:0] flg;} fcd_row_t;
  localparam logic [11:0] CFG = fcd_pkg::ADDR_FLOPPY_CONFIG;
  localparam logic [11:0] IDR = fcd_pkg::ADDR_DRIVE_IDENTIFIER;
  logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic deviceActive = 1'b0, writeProtectIn_n = 1'b1, highRate = 1'b0, driveSel = 1'b0, writeReq = 1'b0;
  logic densitySelectOut, writeProtected, writeGate, altDriveMode;
  logic [1:0] ctrlLow = 2'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] ctrlReadOut, pinOut, pinOutEn_n;
  int failures = 0, checksDone = 0, cycles = 0;
  wire [4:0] flags = {densitySelectOut, writeProtected, writeGate, altDriveMode, pinOutEn_n == 8'hff};
  fcd_row_t rows [5] = '{'{8'h24, 7'h3e, 8'hfe, 5'h14}, '{8'h40, 7'h3d, 8'hdd, 5'h06},
    '{8'h40, 7'h4c, 8'hec, 5'h1a}, '{8'h6d, 7'h5b, 8'hef, 5'h09}, '{8'h25, 7'h74, 8'hfc, 5'h10}};
  floppy_config_drive_identifier_regs dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .deviceActive(deviceActive), .writeProtectIn_n(writeProtectIn_n), .highRate(highRate),
    .driveSel(driveSel), .ctrlLow(ctrlLow), .writeReq(writeReq), .pinOutVal(8'h5a),
    .densitySelectOut(densitySelectOut), .writeProtected(writeProtected), .writeGate(writeGate),
    .altDriveMode(altDriveMode), .ctrlReadOut(ctrlReadOut), .pinOut(pinOut), .pinOutEn_n(pinOutEn_n));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc
  task automatic summarize;
    $display("checksDone=%0d failures=%0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    apb(1'b1, IDR, 32'h9);
    foreach (rows[i]) begin
      apb(1'b1, CFG, 32'(rows[i].cfg));
      {driveSel, highRate, writeProtectIn_n, writeReq, deviceActive, ctrlLow} <= rows[i].ins;
      repeat (2) @(posedge clk_sys);
      check(32'(ctrlReadOut), 32'(rows[i].ctl));
      check(32'(flags), 32'(rows[i].flg));
      rdc(fcd_pkg::ADDR_DRIVE_STATUS, {16'h0, rows[i].ctl, 5'h0, rows[i].flg[3], rows[i].flg[4], rows[i].ins[2]});
    end
    check(32'(pinOut), 32'h5a);
    apb(1'b1, CFG, 32'h6f);
    rdc(CFG, 32'h6f);
    apb(1'b1, IDR, 32'hff);
    rdc(IDR, 32'hf);
    rdc(12'h100, 32'h0);
    check(32'(er), 32'h1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rdc(CFG, 32'h24);
    rdc(IDR, 32'h0);
    check(32'(flags), 32'h10);
    summarize();
  end
endmodule : testbench

// ==== hdl/fcd_apb_slave.sv ====
// APB slave handshake for the floppy configuration block.
`timescale 1ns/1ns
module fcd_apb_slave (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  output logic accept
);
  fcd_pkg::fcd_apb_t state_r;
  fcd_pkg::fcd_apb_t state_nxt;
  // ----------------------------------------------------------------
  // Accept each access phase once, in its first cycle.
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fcd_pkg::FCD_IDLE: begin
        if (psel && !penable) begin
          state_nxt = fcd_pkg::FCD_ACCESS;
        end
      end
      fcd_pkg::FCD_ACCESS: begin
        state_nxt = fcd_pkg::FCD_IDLE;
      end
      default: begin
        state_nxt = fcd_pkg::FCD_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= fcd_pkg::FCD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign accept = (state_r == fcd_pkg::FCD_ACCESS) && psel && penable;
endmodule : fcd_apb_slave

// ==== hdl/fcd_drive_ctrl.sv ====
// Drive control register read-back value from mode and identifier bits.
`timescale 1ns/1ns
module fcd_drive_ctrl (
  input wire logic ctrlMode,
  input wire logic [7:0] driveId,
  input wire logic driveSel,
  input wire logic [1:0] ctrlLow,
  output logic [7:0] ctrlRead
);
  logic [1:0] idBits;
  // ----------------------------------------------------------------
  // Select identifier pair and build the read-back byte.
  // ----------------------------------------------------------------
  always_comb begin
    idBits = driveSel ? driveId[3:2] : driveId[1:0]; // [RQ11] [RQ12]
    if (ctrlMode) begin
      ctrlRead = {2'h3, idBits, 2'h3, ctrlLow}; // [RQ10]
    end else begin
      ctrlRead = {fcd_pkg::COMPAT_UPPER, ctrlLow}; // [RQ3] [RQ14]
    end
  end
endmodule : fcd_drive_ctrl

// ==== hdl/fcd_pkg.sv ====
// Package with register map, field positions and reset values of the floppy configuration block.
package fcd_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses.
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FLOPPY_CONFIG = 8'hf0;
  localparam logic [7:0] IDX_DRIVE_IDENTIFIER = 8'hf1;
  localparam logic [7:0] IDX_DRIVE_STATUS = 8'hf2;
  localparam logic [11:0] ADDR_FLOPPY_CONFIG = {2'h0, IDX_FLOPPY_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_DRIVE_IDENTIFIER = {2'h0, IDX_DRIVE_IDENTIFIER, 2'h0};
  localparam logic [11:0] ADDR_DRIVE_STATUS = {2'h0, IDX_DRIVE_STATUS, 2'h0};
  // ----------------------------------------------------------------
  // Reset values and field positions.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FLOPPY_CONFIG = 8'h24;
  localparam logic [7:0] RST_DRIVE_IDENTIFIER = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h00000000;
  localparam logic [7:0] RST_CTRL_READ = 8'hff;
  localparam logic [7:0] CFG_WR_MASK = 8'h6f;
  localparam logic [7:0] ID_WR_MASK = 8'h0f;
  localparam int BIT_CTRL_MODE = 6;
  localparam int BIT_DENS_POL = 5;
  localparam int BIT_FORCE_WP = 3;
  localparam int BIT_DRIVE_MODE = 2;
  localparam int BIT_HIZ_EN = 0;
  localparam logic [5:0] COMPAT_UPPER = 6'h3f;
  localparam int N_OUT_PINS = 8;
  typedef enum logic [1:0] {FCD_IDLE, FCD_ACCESS} fcd_apb_t;
endpackage : fcd_pkg

// ==== hdl/floppy_config_drive_identifier_regs.sv ====
// Top of the floppy configuration and drive identifier register bank.
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: Config register resets to 24h.
// RQ2: Software writes zero to bits 7 and 4.
// RQ3: Compatible mode reads control bits 7-2 as ones.
// RQ4: Bit 5 sets density output polarity.
// RQ5: Bit 3 forces write protect.
// RQ6: Forced protect blocks writes like input.
// RQ7: Bit 2 selects drive interface mode.
// RQ8: Bit 0 floats outputs while inactive.
// RQ9: Identifier register resets to 00h.
// RQ10: Enhanced mode identifier feeds control bits 5-4.
// RQ11: Drive 1 shows identifier bits 3-2.
// RQ12: Drive 0 shows identifier bits 1-0.
// RQ13: Software sets id bit without media sense.
// RQ14: Compatible mode ignores identifier contents.
module floppy_config_drive_identifier_regs (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic deviceActive,
  input wire logic writeProtectIn_n,
  input wire logic highRate,
  input wire logic driveSel,
  input wire logic [1:0] ctrlLow,
  input wire logic writeReq,
  input wire logic [7:0] pinOutVal,
  output logic densitySelectOut,
  output logic writeProtected,
  output logic writeGate,
  output logic altDriveMode,
  output logic [7:0] ctrlReadOut,
  output logic [7:0] pinOut,
  output logic [7:0] pinOutEn_n
);
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] id_r;
  logic [7:0] id_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic dens_r;
  logic dens_nxt;
  logic wp_r;
  logic wp_nxt;
  logic wg_r;
  logic wg_nxt;
  logic alt_r;
  logic alt_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic accept;
  logic commit;
  logic [7:0] ctrlRead;
  logic selCfg;
  logic selId;
  logic selStatus;
  logic hit;
  logic badAccess;
  logic wrCfg;
  logic wrId;
  logic [7:0] cfgWrite;
  logic [7:0] idWrite;
  logic [7:0] statusLow;
  logic [31:0] readWord;
  logic protectNow;
  logic floatPins;
  // ----------------------------------------------------------------
  // Bus handshake.
  // ----------------------------------------------------------------
  fcd_apb_slave u_apb (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .accept(accept)
  );
  // A write lands at the edge at which the master samples pready high.
  assign commit = pready_r && psel && penable;
  // ----------------------------------------------------------------
  // Address decode and write data.
  // ----------------------------------------------------------------
  always_comb begin
    selCfg = (paddr == fcd_pkg::ADDR_FLOPPY_CONFIG);
    selId = (paddr == fcd_pkg::ADDR_DRIVE_IDENTIFIER);
    selStatus = (paddr == fcd_pkg::ADDR_DRIVE_STATUS);
    hit = selCfg || selId || selStatus;
    badAccess = !hit || (pwrite && selStatus);
    wrCfg = commit && pwrite && pstrb[0] && selCfg;
    wrId = commit && pwrite && pstrb[0] && selId;
    cfgWrite = pwdata[7:0] & fcd_pkg::CFG_WR_MASK; // [RQ2]
    idWrite = pwdata[7:0] & fcd_pkg::ID_WR_MASK;
  end
  // ----------------------------------------------------------------
  // Drive control read-back composition.
  // ----------------------------------------------------------------
  fcd_drive_ctrl u_ctrl (
    .ctrlMode(cfg_r[fcd_pkg::BIT_CTRL_MODE]),
    .driveId(id_r),
    .driveSel(driveSel),
    .ctrlLow(ctrlLow),
    .ctrlRead(ctrlRead)
  );
  // ----------------------------------------------------------------
  // Read data selection.
  // ----------------------------------------------------------------
  always_comb begin
    statusLow = {5'h00, wp_r, dens_r, deviceActive};
    case (paddr)
      fcd_pkg::ADDR_FLOPPY_CONFIG: begin
        readWord = {24'h000000, cfg_r};
      end
      fcd_pkg::ADDR_DRIVE_IDENTIFIER: begin
        readWord = {24'h000000, id_r};
      end
      fcd_pkg::ADDR_DRIVE_STATUS: begin
        readWord = {16'h0000, ctrlRead, statusLow};
      end
      default: begin
        readWord = 32'h00000000;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // Ready response.
  // ----------------------------------------------------------------
  always_comb begin
    pready_nxt = accept;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Error response.
  // ----------------------------------------------------------------
  always_comb begin
    pslverr_nxt = accept && badAccess;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= pslverr_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Read data register.
  // ----------------------------------------------------------------
  always_comb begin
    prdata_nxt = prdata_r;
    if (accept && !pwrite) begin
      prdata_nxt = readWord;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= fcd_pkg::RST_RDATA;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Configuration and identifier registers.
  // ----------------------------------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    id_nxt = id_r;
    if (wrCfg) begin
      cfg_nxt = cfgWrite;
    end
    if (wrId) begin
      id_nxt = idWrite;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= fcd_pkg::RST_FLOPPY_CONFIG; // [RQ1]
      id_r <= fcd_pkg::RST_DRIVE_IDENTIFIER; // [RQ9]
    end else begin
      cfg_r <= cfg_nxt;
      id_r <= id_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Density select output.
  // ----------------------------------------------------------------
  always_comb begin
    dens_nxt = cfg_r[fcd_pkg::BIT_DENS_POL] ? highRate : !highRate; // [RQ4]
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dens_r <= 1'b0;
    end else begin
      dens_r <= dens_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Write protection.
  // ----------------------------------------------------------------
  always_comb begin
    protectNow = cfg_r[fcd_pkg::BIT_FORCE_WP] || !writeProtectIn_n; // [RQ5]
    wp_nxt = protectNow; // [RQ5]
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Write gate.
  // ----------------------------------------------------------------
  always_comb begin
    wg_nxt = writeReq && !protectNow; // [RQ6]
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wg_r <= 1'b0;
    end else begin
      wg_r <= wg_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Drive interface mode.
  // ----------------------------------------------------------------
  always_comb begin
    alt_nxt = !cfg_r[fcd_pkg::BIT_DRIVE_MODE]; // [RQ7]
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      alt_r <= 1'b0;
    end else begin
      alt_r <= alt_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Drive control read-back register.
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrlRead; // [RQ3] [RQ10]
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= fcd_pkg::RST_CTRL_READ;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Output pins and their enables.
  // ----------------------------------------------------------------
  always_comb begin
    floatPins = cfg_r[fcd_pkg::BIT_HIZ_EN] && !deviceActive; // [RQ8]
  end
  for (genvar p = 0; p < fcd_pkg::N_OUT_PINS; p++) begin : g_pin
    logic pinBit_r;
    logic pinBit_nxt;
    logic oenBit_r;
    logic oenBit_nxt;
    always_comb begin
      pinBit_nxt = pinOutVal[p];
      oenBit_nxt = floatPins; // [RQ8]
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        pinBit_r <= 1'b0;
        oenBit_r <= 1'b0;
      end else begin
        pinBit_r <= pinBit_nxt;
        oenBit_r <= oenBit_nxt;
      end
    end
    assign pinOut[p] = pinBit_r;
    assign pinOutEn_n[p] = oenBit_r;
  end
  // ----------------------------------------------------------------
  // Port outputs.
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign densitySelectOut = dens_r;
  assign writeProtected = wp_r;
  assign writeGate = wg_r;
  assign altDriveMode = alt_r;
  assign ctrlReadOut = ctrl_r;
endmodule : floppy_config_drive_identifier_regs
